// >>> core/spi_flags_pkg.sv
// package: register layout, reset value and carrier types of the spi control/status block
package spi_flags_pkg;
    localparam int unsigned REG_WIDTH = 8;
    localparam logic [7:0] SPI_CONTROL_RESET = 8'h06;
    localparam int unsigned BIT_TRANSFER_DONE = 7;
    localparam int unsigned BIT_WRITE_COLLISION = 6;
    localparam int unsigned BIT_MODE_FAULT = 5;
    localparam int unsigned BIT_RECEIVE_OVERRUN = 4;
    localparam int unsigned BIT_SSMODE_HI = 3;
    localparam int unsigned BIT_SSMODE_LO = 2;
    localparam int unsigned BIT_TX_EMPTY = 1;
    localparam int unsigned BIT_PORT_ENABLE = 0;
    localparam logic [1:0] SSMODE_3WIRE = 2'h0;
    localparam logic [1:0] SSMODE_4WIRE_SLAVE = 2'h1;
    localparam logic [1:0] SSMODE_RESET = 2'h1;
    localparam int unsigned BITS_PER_BYTE = 8;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic slave_select_n;
    } spi_pins_in_type;

    typedef struct packed {
        logic sck;
        logic sck_oe;
        logic mosi;
        logic mosi_oe;
        logic miso;
        logic miso_oe;
        logic slave_select_n;
        logic slave_select_n_oe;
    } spi_pins_out_type;
endpackage

// >>> core/spi_control_status_flags.sv
// spi control register flags with a minimal byte shift engine
//
// Behaviour
// - transfer_done_flag is set when a byte transfer ends and only software clears it.
// - a data write while the transmit buffer is full sets write_collision_flag.
// - a master-mode collision is slave select low, master_enable high and mode 01.
// - a master-mode collision sets mode_fault_flag until software clears it.
`timescale 1ns/10ps
module spi_control_status_flags (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ctrl_write,
    input wire logic [7:0] ctrl_wdata,
    output logic [7:0] ctrl_rdata,
    input wire logic master_enable,
    input wire logic data_write,
    input wire logic [7:0] data_wdata,
    input wire logic data_read,
    output logic [7:0] data_rdata,
    output logic spi_interrupt,
    input wire spi_flags_pkg::spi_pins_in_type pins_in,
    output spi_flags_pkg::spi_pins_out_type pins_out
);
    import spi_flags_pkg::*;

    // ==========================================
    // reset release
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ==========================================
    // pin synchronisers
    logic [2:0] sck_sync;
    logic [2:0] mosi_sync;
    logic [2:0] nss_sync;
    logic sck_level;
    logic mosi_level;
    logic nss_level;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sck_sync <= 3'h0;
            mosi_sync <= 3'h0;
            nss_sync <= 3'h7;
            sck_level <= 1'b0;
            mosi_level <= 1'b0;
            nss_level <= 1'b1;
        end else begin
            sck_sync <= {sck_sync[1:0], pins_in.sck};
            mosi_sync <= {mosi_sync[1:0], pins_in.mosi};
            nss_sync <= {nss_sync[1:0], pins_in.slave_select_n};
            if (sck_sync[1] == sck_sync[2]) begin
                sck_level <= sck_sync[2];
            end
            if (mosi_sync[1] == mosi_sync[2]) begin
                mosi_level <= mosi_sync[2];
            end
            if (nss_sync[1] == nss_sync[2]) begin
                nss_level <= nss_sync[2];
            end
        end
    end

    // ==========================================
    // control fields
    logic port_enable;
    logic [1:0] slave_select_mode;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            port_enable <= SPI_CONTROL_RESET[BIT_PORT_ENABLE];
            slave_select_mode <= SSMODE_RESET;
        end else if (ctrl_write) begin
            port_enable <= ctrl_wdata[BIT_PORT_ENABLE];
            slave_select_mode <= ctrl_wdata[BIT_SSMODE_HI:BIT_SSMODE_LO];
        end
    end

    // ==========================================
    // slave shift engine
    logic sck_prev;
    logic sck_rise;
    logic [7:0] shift;
    logic [2:0] bit_count;
    logic transfer_end;
    logic [7:0] tx_buffer;
    logic transmit_buffer_empty;
    logic rx_full;
    logic slave_active;
    assign sck_rise = sck_level && !sck_prev;
    assign slave_active = port_enable && !master_enable && !nss_level;
    assign transfer_end = slave_active && sck_rise && (bit_count == 3'(BITS_PER_BYTE - 1));
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev <= 1'b0;
            shift <= 8'h00;
            bit_count <= 3'h0;
        end else begin
            sck_prev <= sck_level;
            if (!slave_active) begin
                bit_count <= 3'h0;
                if (!transmit_buffer_empty) begin
                    shift <= tx_buffer;
                end
            end else if (sck_rise) begin
                shift <= {shift[6:0], mosi_level};
                bit_count <= bit_count + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_buffer <= 8'h00;
            transmit_buffer_empty <= 1'b1;
        end else if (data_write && transmit_buffer_empty) begin
            tx_buffer <= data_wdata;
            transmit_buffer_empty <= 1'b0;
        end else if (!slave_active && !transmit_buffer_empty) begin
            transmit_buffer_empty <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_rdata <= 8'h00;
            rx_full <= 1'b0;
        end else if (transfer_end) begin
            data_rdata <= {shift[6:0], mosi_level};
            rx_full <= 1'b1;
        end else if (data_read) begin
            rx_full <= 1'b0;
        end
    end

    // ==========================================
    // sticky flags, set wins over clear
    logic transfer_done_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic receive_overrun_flag;
    logic mode_collision;
    logic write_collision;
    logic receive_overrun;
    logic clear_transfer_done;
    logic clear_write_collision;
    logic clear_mode_fault;
    logic clear_receive_overrun;
    assign mode_collision = !nss_level && master_enable
        && (slave_select_mode == SSMODE_4WIRE_SLAVE);
    assign write_collision = data_write && !transmit_buffer_empty;
    assign receive_overrun = transfer_end && rx_full;
    // writing zero to a flag bit clears it, writing one leaves it
    assign clear_transfer_done = ctrl_write && !ctrl_wdata[BIT_TRANSFER_DONE];
    assign clear_write_collision = ctrl_write && !ctrl_wdata[BIT_WRITE_COLLISION];
    assign clear_mode_fault = ctrl_write && !ctrl_wdata[BIT_MODE_FAULT];
    assign clear_receive_overrun = ctrl_write && !ctrl_wdata[BIT_RECEIVE_OVERRUN];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            transfer_done_flag <= SPI_CONTROL_RESET[BIT_TRANSFER_DONE];
        end else if (transfer_end) begin
            transfer_done_flag <= 1'b1;
        end else if (clear_transfer_done) begin
            transfer_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            write_collision_flag <= SPI_CONTROL_RESET[BIT_WRITE_COLLISION];
        end else if (write_collision) begin
            write_collision_flag <= 1'b1;
        end else if (clear_write_collision) begin
            write_collision_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_fault_flag <= SPI_CONTROL_RESET[BIT_MODE_FAULT];
        end else if (mode_collision) begin
            mode_fault_flag <= 1'b1;
        end else if (clear_mode_fault) begin
            mode_fault_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            receive_overrun_flag <= SPI_CONTROL_RESET[BIT_RECEIVE_OVERRUN];
        end else if (receive_overrun) begin
            receive_overrun_flag <= 1'b1;
        end else if (clear_receive_overrun) begin
            receive_overrun_flag <= 1'b0;
        end
    end

    // ==========================================
    // register readback and outputs
    assign ctrl_rdata = {transfer_done_flag, write_collision_flag, mode_fault_flag,
        receive_overrun_flag, slave_select_mode, transmit_buffer_empty, port_enable};
    assign spi_interrupt = transfer_done_flag || write_collision_flag
        || mode_fault_flag || receive_overrun_flag;

    logic miso_bit;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            miso_bit <= 1'b0;
        end else begin
            miso_bit <= shift[7];
        end
    end

    always_comb begin
        pins_out = '0;
        pins_out.miso = miso_bit;
        pins_out.miso_oe = slave_active;
    end
endmodule

// >>> test/spi_flags_assertions.sv
// checker for the flag behaviour of the spi control block
`timescale 1ns/10ps
module spi_flags_assertions (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ctrl_write,
    input wire logic [7:0] ctrl_rdata,
    input wire logic master_enable,
    input wire logic data_write,
    input wire logic spi_interrupt,
    input wire spi_flags_pkg::spi_pins_in_type pins_in
);
    import spi_flags_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_collide;
        !pins_in.slave_select_n && master_enable && ctrl_rdata[3:2] == SSMODE_4WIRE_SLAVE;
    endsequence
    sequence s_deselected;
        pins_in.slave_select_n [*8];
    endsequence
    property p_done_hold;
        ctrl_rdata[7] && !ctrl_write |=> ctrl_rdata[7];
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("done flag dropped");
    property p_write_collision_flag_set;
        data_write && !ctrl_rdata[1] |=> ctrl_rdata[6] && spi_interrupt;
    endproperty
    a_write_collision_flag_set: assert property (p_write_collision_flag_set)
        else $error("collision flag not set");
    property p_fault_cause;
        s_deselected |-> !$rose(ctrl_rdata[5]);
    endproperty
    a_fault_cause: assert property (p_fault_cause)
        else $error("fault flag without select");
    property p_fault_set;
        s_collide [*6] |-> ctrl_rdata[5] && spi_interrupt;
    endproperty
    a_fault_set: assert property (p_fault_set)
        else $error("fault flag not set");
    property p_ovr_hold;
        ctrl_rdata[4] && !ctrl_write |=> ctrl_rdata[4];
    endproperty
    a_ovr_hold: assert property (p_ovr_hold)
        else $error("overrun flag dropped");
endmodule
bind spi_control_status_flags spi_flags_assertions i_spi_flags_assertions (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ctrl_write(ctrl_write),
    .ctrl_rdata(ctrl_rdata),
    .master_enable(master_enable),
    .data_write(data_write),
    .spi_interrupt(spi_interrupt),
    .pins_in(pins_in)
);

// >>> test/spi_master_model.sv
// external spi master driving clock, data and select
`timescale 1ns/10ps
module spi_master_model (
    output spi_flags_pkg::spi_pins_in_type pins
);
    import spi_flags_pkg::*;
    initial pins = '{sck: 1'b0, mosi: 1'b0, slave_select_n: 1'b1};
    task automatic select(input logic level);
        pins.slave_select_n = level;
    endtask
    task automatic send(input logic [7:0] value);
        pins.slave_select_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            pins.mosi = value[i];
            #400 pins.sck = 1'b1;
            #400 pins.sck = 1'b0;
        end
        #400 pins.slave_select_n = 1'b1;
        pins.mosi = ~pins.mosi;
    endtask
endmodule

// >>> test/test_spi_control_status_flags.sv
// testbench for the spi control/status flags
`timescale 1ns/10ps
module test_spi_control_status_flags;
    import spi_flags_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic ctrl_write = 1'b0;
    logic master_enable = 1'b0;
    logic data_write = 1'b0;
    logic data_read = 1'b0;
    logic [7:0] ctrl_wdata = 8'h00;
    logic [7:0] data_wdata = 8'h00;
    logic [7:0] ctrl_rdata;
    logic [7:0] data_rdata;
    logic spi_interrupt;
    spi_pins_in_type pins_in;
    spi_pins_out_type pins_out;
    int n_mismatch = 0;
    int checks = 0;
    spi_master_model i_spi_master_model (.pins(pins_in));
    spi_control_status_flags i_spi_control_status_flags (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ctrl_write(ctrl_write),
        .ctrl_wdata(ctrl_wdata),
        .ctrl_rdata(ctrl_rdata),
        .master_enable(master_enable),
        .data_write(data_write),
        .data_wdata(data_wdata),
        .data_read(data_read),
        .data_rdata(data_rdata),
        .spi_interrupt(spi_interrupt),
        .pins_in(pins_in),
        .pins_out(pins_out)
    );
    initial forever #50 clk_sys = ~clk_sys;
    task automatic final_report();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        checks++;
        if (seen !== expected) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, expected);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic ctrl_wr(input logic [7:0] value);
        ctrl_wdata = value;
        ctrl_write = 1'b1;
        tick(1);
        ctrl_write = 1'b0;
        tick(1);
    endtask
    task automatic data_wr(input logic [7:0] value);
        data_wdata = value;
        data_write = 1'b1;
        tick(1);
        data_write = 1'b0;
        tick(2);
    endtask
    task automatic wait_flag(input int pos);
        int n;
        n = 0;
        while (ctrl_rdata[pos] !== 1'b1 && n < 50) begin
            tick(1);
            n++;
        end
        if (ctrl_rdata[pos] !== 1'b1) begin
            n_mismatch++;
            final_report();
        end
    endtask
    initial begin
        tick(5);
        resetn = 1'b1;
        tick(3);
        check(ctrl_rdata, SPI_CONTROL_RESET);
        ctrl_wr(8'hF5);
        check(ctrl_rdata, 8'h07);
        i_spi_master_model.send(8'hA5);
        wait_flag(7);
        check(data_rdata, 8'hA5);
        ctrl_wr(8'hF5);
        tick(20);
        check(ctrl_rdata, 8'h87);
        i_spi_master_model.send(8'h3C);
        wait_flag(4);
        check(ctrl_rdata, 8'h97);
        data_read = 1'b1;
        tick(1);
        data_read = 1'b0;
        ctrl_wr(8'h05);
        check({7'h00, spi_interrupt}, 8'h00);
        i_spi_master_model.select(1'b0);
        tick(6);
        check(pins_out, 8'h04);
        data_wr(8'h11);
        data_wr(8'h22);
        data_wr(8'h33);
        check(ctrl_rdata, 8'h45);
        ctrl_wr(8'h05);
        check(ctrl_rdata, 8'h05);
        master_enable = 1'b1;
        tick(8);
        check(ctrl_rdata, 8'h27);
        ctrl_wr(8'hF1);
        ctrl_wr(8'h01);
        tick(8);
        check(ctrl_rdata, 8'h03);
        i_spi_master_model.select(1'b1);
        master_enable = 1'b0;
        final_report();
    end
endmodule
